// ### design/rtccs_params.svh
`ifndef RTCCS_PARAMS_SVH
`define RTCCS_PARAMS_SVH
`define RTCCS_ADDR_SEC 4'h0
`define RTCCS_ADDR_ADJ 4'h7
`define RTCCS_ADDR_CTL1 4'he
`define RTCCS_ADDR_CTL2 4'hf
`define RTCCS_CTL1_RST 8'h00
`define RTCCS_CTL2_RST 8'h10
`define RTCCS_ADJ_RST 8'h00
`define RTCCS_PON_BIT 4
`define RTCCS_XST_BIT 5
`define RTCCS_CLK_NS 40
`define RTCCS_SEC_DLY_NS 92000
`define RTCCS_SEC_DLY_CYC (`RTCCS_SEC_DLY_NS / `RTCCS_CLK_NS)
`define RTCCS_ALM_DLY_NS 61000
`define RTCCS_ALM_DLY_CYC (`RTCCS_ALM_DLY_NS / `RTCCS_CLK_NS)
`define RTCCS_DIV_TOP 16'h7fff
`define RTCCS_HALF_BIT 14
`define RTCCS_QTR_BIT 13
`define RTCCS_ADJ_SEC 6'h3b
`define RTCCS_OSC_HZ 64'd32768
`define RTCCS_ADJ_MAX_NS 64'd3784000
`define RTCCS_ADJ_MAX_TK \
    ((`RTCCS_ADJ_MAX_NS * `RTCCS_OSC_HZ) / 64'd1000000000)
`endif

// ### design/rtccs_pkg.sv
package rtccs_pkg;
    typedef enum logic [1:0] {
        RTCCS_PM_OFF,
        RTCCS_PM_LOW,
        RTCCS_PM_PULSE,
        RTCCS_PM_LEVEL
    } rtccs_pmode_e;

    typedef struct packed {
        logic weekly_alarm_enable;
        logic daily_alarm_enable;
        logic hour24_select;
        logic clkout_disable_b;
        logic test_mode;
        logic periodic_select_b2;
        logic periodic_select_b1;
        logic periodic_select_b0;
    } rtccs_ctl1_s;

    typedef struct packed {
        logic supply_threshold_select;
        logic supply_low_flag;
        logic osc_halt_flag_n;
        logic poweron_flag;
        logic clkout_disable_a;
        logic periodic_irq_flag;
        logic weekly_alarm_flag;
        logic daily_alarm_flag;
    } rtccs_ctl2_s;

    typedef struct packed {
        logic wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } rtccs_req_s;

    typedef struct packed {
        logic sec_zero;
        logic min_zero;
        logic hour_zero;
        logic day_one;
    } rtccs_next_s;
endpackage : rtccs_pkg

// ### design/rtccs_core.sv
// Behaviour
// - Alarm enable bits gate each alarm interrupt
// - Hour format bit: 0 twelve-hour, 1 twenty-four
// - Twelve-hour BCD, bit 5 marks afternoon
// - Clock out stops only when both disables set
// - Test bit stored; host keeps it zero
// - Selector codes: off, low, pulse, level
// - Pulse mode 2 Hz or 1 Hz, half duty
// - Pulse mode: second advances 92 us later
// - Second write clears divider, pulse output low
// - Level codes: second, minute, hour, month
// - Level falling edge meets second increment
// - Adjustment bends one second per minute
// - Power-up: control two reads only power-on set
// - Threshold bit: 0 is 2.1 V, 1 is 1.3 V
// - Supply-low flag sticks, monitoring continues
// - Writing 0 clears supply-low, set again while supply still low
// - Periodic flag mirrors low output, level clear
// - Power-on flag holds control bits at zero, except XST
// - Alarm flags set 61 us after enabled match
`timescale 1ns/10ps
`include "rtccs_params.svh"
`default_nettype none
module rtccs_core
    import rtccs_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire rtccs_req_s reg_req,
    output logic [7:0] reg_rdata,
    input wire logic osc_clk,
    input wire logic osc_tick,
    input wire logic osc_halted,
    input wire logic vdd_below_2v1,
    input wire logic vdd_below_1v3,
    input wire logic [1:0] alarm_match,
    input wire rtccs_next_s next_count,
    input wire logic [4:0] hour_bin,
    output logic [5:0] hour_code,
    output logic sec_inc,
    output logic irq_out_n,
    output logic clkout_pin
);
    localparam logic [15:0] SEC_DLY = 16'(`RTCCS_SEC_DLY_CYC);
    localparam logic [15:0] ALM_DLY = 16'(`RTCCS_ALM_DLY_CYC);
    localparam logic [6:0] ADJ_MAX = 7'(`RTCCS_ADJ_MAX_TK);

    rtccs_ctl1_s c1_r, c1_nxt;
    rtccs_ctl2_s c2_r, c2_nxt;
    logic [7:0] adj_r, adj_nxt;
    logic [15:0] div_r, div_nxt;
    logic [5:0] sec60_r, sec60_nxt;
    logic [15:0] sdly_r, sdly_nxt;
    logic [15:0] alm_cnt_r [2];
    logic [15:0] alm_cnt_nxt [2];
    logic [7:0] rdata_nxt;
    logic [5:0] hour_nxt;
    logic sec_inc_nxt, irq_nxt, clkout_nxt;

    logic wr_sec, wr_adj, wr_c1, wr_c2, wrap, pulse_low, lvl_event;
    logic mon_low, periodic_irq_flag_clr;
    logic [15:0] term;
    logic [6:0] adj_tk;
    logic [1:0] alm_en, alm_flag, alm_clr, alm_set;
    rtccs_pmode_e pmode;

    function automatic logic [5:0] hour_enc(input logic [4:0] h,
                                            input logic h24);
        logic [4:0] v;
        logic pm;
        v = h;
        pm = 1'b0;
        if (!h24) begin
            pm = (h >= 5'd12);
            v = pm ? 5'(h - 5'd12) : h;
            v = (v == 5'd0) ? 5'd12 : v;
        end
        if (v >= 5'd20) begin
            hour_enc = {2'b10, 4'(v - 5'd20)};
        end else if (v >= 5'd10) begin
            hour_enc = {2'b01, 4'(v - 5'd10)};
        end else begin
            hour_enc = {2'b00, v[3:0]};
        end
        hour_enc[5] = hour_enc[5] | pm;
    endfunction : hour_enc

    always_comb begin
        wr_sec = reg_req.wr && reg_req.addr == `RTCCS_ADDR_SEC;
        wr_adj = reg_req.wr && reg_req.addr == `RTCCS_ADDR_ADJ;
        wr_c1 = reg_req.wr && reg_req.addr == `RTCCS_ADDR_CTL1;
        wr_c2 = reg_req.wr && reg_req.addr == `RTCCS_ADDR_CTL2;

        unique case ({c1_r.periodic_select_b2, c1_r.periodic_select_b1})
            2'b00: pmode = c1_r.periodic_select_b0 ? RTCCS_PM_LOW
                                                   : RTCCS_PM_OFF;
            2'b01: pmode = RTCCS_PM_PULSE;
            default: pmode = RTCCS_PM_LEVEL;
        endcase

        // Adjustment in steps of two oscillator ticks, capped
        adj_tk = ({adj_r[5:0], 1'b0} > ADJ_MAX) ? ADJ_MAX
                                                 : {adj_r[5:0], 1'b0};
        term = `RTCCS_DIV_TOP;
        if (sec60_r == `RTCCS_ADJ_SEC && adj_r[5:0] != 6'h00) begin
            term = adj_r[6] ? 16'(term - {9'h000, adj_tk})
                            : 16'(term + {9'h000, adj_tk});
        end

        div_nxt = div_r;
        wrap = 1'b0;
        if (wr_sec) begin
            div_nxt = 16'h0000;
        end else if (osc_tick) begin
            if (div_r >= term) begin
                div_nxt = 16'h0000;
                wrap = 1'b1;
            end else begin
                div_nxt = 16'(div_r + 16'h0001);
            end
        end
        sec60_nxt = sec60_r;
        if (wrap) begin
            sec60_nxt = (sec60_r == `RTCCS_ADJ_SEC) ? 6'h00
                                                  : 6'(sec60_r + 6'h01);
        end

        // Low half first: the falling edge opens each second
        if (c1_r.periodic_select_b0) begin
            pulse_low = div_nxt[15:`RTCCS_HALF_BIT] == 2'b00
                        || div_nxt[15];
        end else begin
            pulse_low = !div_nxt[`RTCCS_QTR_BIT];
        end

        // Pulse mode lets the counter step a little after the edge
        sdly_nxt = (sdly_r != 16'h0000) ? 16'(sdly_r - 16'h0001)
                                        : 16'h0000;
        sec_inc_nxt = 1'b0;
        if (wrap && pmode == RTCCS_PM_PULSE) begin
            sdly_nxt = SEC_DLY;
        end else if (wrap) begin
            sec_inc_nxt = 1'b1;
        end
        if (sdly_r == 16'h0001) begin
            sec_inc_nxt = 1'b1;
        end

        unique case ({c1_r.periodic_select_b1, c1_r.periodic_select_b0})
            2'b00: lvl_event = wrap;
            2'b01: lvl_event = wrap && next_count.sec_zero;
            2'b10: lvl_event = wrap && next_count.sec_zero
                               && next_count.min_zero;
            default: lvl_event = wrap && next_count.sec_zero
                                 && next_count.min_zero
                                 && next_count.hour_zero
                                 && next_count.day_one;
        endcase

        c1_nxt = c1_r;
        if (wr_c1) begin
            c1_nxt = rtccs_ctl1_s'(reg_req.wdata);
        end
        adj_nxt = wr_adj ? reg_req.wdata : adj_r;

        c2_nxt = c2_r;
        if (wr_c2) begin
            c2_nxt.supply_threshold_select = reg_req.wdata[7];
            c2_nxt.clkout_disable_a = reg_req.wdata[3];
            c2_nxt.osc_halt_flag_n = reg_req.wdata[`RTCCS_XST_BIT];
            if (!reg_req.wdata[`RTCCS_PON_BIT]) begin
                c2_nxt.poweron_flag = 1'b0;
            end
        end
        if (osc_halted) begin
            c2_nxt.osc_halt_flag_n = 1'b0;
        end

        // Set wins over a clear arriving in the same cycle
        mon_low = c2_r.supply_threshold_select ? vdd_below_1v3
                                               : vdd_below_2v1;
        c2_nxt.supply_low_flag = (c2_r.supply_low_flag
                                  && !(wr_c2 && !reg_req.wdata[6]))
                                 || mon_low;

        periodic_irq_flag_clr = wr_c2 && !reg_req.wdata[2];
        unique case (pmode)
            RTCCS_PM_OFF: c2_nxt.periodic_irq_flag = 1'b0;
            RTCCS_PM_LOW: c2_nxt.periodic_irq_flag = 1'b1;
            RTCCS_PM_PULSE: c2_nxt.periodic_irq_flag = pulse_low;
            RTCCS_PM_LEVEL: c2_nxt.periodic_irq_flag =
                (c2_r.periodic_irq_flag && !periodic_irq_flag_clr)
                || lvl_event;
        endcase

        alm_en = {c1_r.weekly_alarm_enable, c1_r.daily_alarm_enable};
        alm_clr = {wr_c2 && !reg_req.wdata[1], wr_c2 && !reg_req.wdata[0]};
        alm_flag = {c2_r.weekly_alarm_flag, c2_r.daily_alarm_flag};
        for (int i = 0; i < 2; i++) begin
            alm_cnt_nxt[i] = 16'h0000;
            if (alm_en[i] && alarm_match[i]) begin
                alm_cnt_nxt[i] = ALM_DLY;
            end else if (alm_en[i] && alm_cnt_r[i] != 16'h0000) begin
                alm_cnt_nxt[i] = 16'(alm_cnt_r[i] - 16'h0001);
            end
            alm_set[i] = alm_en[i] && alm_cnt_r[i] == 16'h0001;
            alm_flag[i] = alm_en[i] && ((alm_flag[i] && !alm_clr[i])
                                        || alm_set[i]);
        end
        c2_nxt.weekly_alarm_flag = alm_flag[1];
        c2_nxt.daily_alarm_flag = alm_flag[0];

        if (c2_r.poweron_flag) begin
            c1_nxt = `RTCCS_CTL1_RST;
            adj_nxt = `RTCCS_ADJ_RST;
            c2_nxt = rtccs_ctl2_s'({3'b000, c2_nxt.poweron_flag, 4'h0})
                     | rtccs_ctl2_s'({2'b00, c2_nxt.osc_halt_flag_n,
                                      5'h00});
        end

        irq_nxt = !(c2_nxt.periodic_irq_flag || c2_nxt.weekly_alarm_flag
                    || c2_nxt.daily_alarm_flag);
        clkout_nxt = (c1_nxt.clkout_disable_b && c2_nxt.clkout_disable_a)
                     || osc_clk;
        hour_nxt = hour_enc(hour_bin, c1_r.hour24_select);

        unique case (reg_req.addr)
            `RTCCS_ADDR_ADJ: rdata_nxt = adj_r;
            `RTCCS_ADDR_CTL1: rdata_nxt = c1_r;
            `RTCCS_ADDR_CTL2: rdata_nxt = c2_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            c1_r <= `RTCCS_CTL1_RST;
            c2_r <= `RTCCS_CTL2_RST;
            adj_r <= `RTCCS_ADJ_RST;
            div_r <= 16'h0000;
            sec60_r <= 6'h00;
            sdly_r <= 16'h0000;
            alm_cnt_r[0] <= 16'h0000;
            alm_cnt_r[1] <= 16'h0000;
            reg_rdata <= 8'h00;
            hour_code <= 6'h00;
            sec_inc <= 1'b0;
            irq_out_n <= 1'b1;
            clkout_pin <= 1'b1;
        end else begin
            c1_r <= c1_nxt;
            c2_r <= c2_nxt;
            adj_r <= adj_nxt;
            div_r <= div_nxt;
            sec60_r <= sec60_nxt;
            sdly_r <= sdly_nxt;
            alm_cnt_r[0] <= alm_cnt_nxt[0];
            alm_cnt_r[1] <= alm_cnt_nxt[1];
            reg_rdata <= rdata_nxt;
            hour_code <= hour_nxt;
            sec_inc <= sec_inc_nxt;
            irq_out_n <= irq_nxt;
            clkout_pin <= clkout_nxt;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_clkout;
        !(c1_nxt.clkout_disable_b && c2_nxt.clkout_disable_a)
            |=> clkout_pin == $past(osc_clk);
    endproperty
    a_clkout: assert property (p_clkout)
        else $error("clock output not following oscillator");

    property p_off_mode;
        pmode == RTCCS_PM_OFF && !alm_flag[0] && !alm_flag[1]
            |=> irq_out_n;
    endproperty
    a_off_mode: assert property (p_off_mode)
        else $error("interrupt low while periodic off");

    property p_pulse_delay;
        wrap && pmode == RTCCS_PM_PULSE |=> sdly_r == SEC_DLY && !sec_inc;
    endproperty
    a_pulse_delay: assert property (p_pulse_delay)
        else $error("second step not delayed in pulse mode");

    property p_sec_write;
        wr_sec && pmode == RTCCS_PM_PULSE && !c2_r.poweron_flag
            |=> div_r == 16'h0000 && !irq_out_n;
    endproperty
    a_sec_write: assert property (p_sec_write)
        else $error("second write did not clear divider");

    property p_level_edge;
        wrap && pmode == RTCCS_PM_LEVEL && !c1_r.periodic_select_b0
            && !c1_r.periodic_select_b1
            |=> sec_inc && c2_r.periodic_irq_flag && !irq_out_n;
    endproperty
    a_level_edge: assert property (p_level_edge)
        else $error("level event not aligned with second");

    property p_supply_low_flag_sticky;
        c2_r.supply_low_flag && !wr_c2 |=> c2_r.supply_low_flag;
    endproperty
    a_supply_low_flag_sticky: assert property (p_supply_low_flag_sticky)
        else $error("supply-low flag dropped by itself");

    property p_supply_low_flag_clr;
        wr_c2 && !reg_req.wdata[6] && !mon_low |=> !c2_r.supply_low_flag;
    endproperty
    a_supply_low_flag_clr: assert property (p_supply_low_flag_clr)
        else $error("supply-low flag not cleared");

    property p_pon_hold;
        c2_r.poweron_flag |-> c1_r == `RTCCS_CTL1_RST
            && adj_r == `RTCCS_ADJ_RST && !c2_r.clkout_disable_a;
    endproperty
    a_pon_hold: assert property (p_pon_hold)
        else $error("control bits not held during power-on");

    property p_alarm_dis;
        !c1_r.weekly_alarm_enable |=> !c2_r.weekly_alarm_flag;
    endproperty
    a_alarm_dis: assert property (p_alarm_dis)
        else $error("alarm flag set while disabled");

    property p_hour12;
        hour_bin == 5'd12 && !c1_r.hour24_select |=> hour_code == 6'h32;
    endproperty
    a_hour12: assert property (p_hour12)
        else $error("noon not coded as 32");
endmodule : rtccs_core
`default_nettype wire

// ### tb/rtccs_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module rtccs_host_model
    import rtccs_pkg::*;
(
    input wire logic clock,
    output var rtccs_req_s reg_req,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_req = '0;
    end

    // Data is scrambled once the strobe drops, so stale bytes never match
    task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_req <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge clock);
        reg_req <= '{wr: 1'b0, addr: a, wdata: ~d};
    endtask : write_reg

    task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_req <= '{wr: 1'b0, addr: a, wdata: 8'h5a};
        repeat (2) @(posedge clock);
        #1;
        d = reg_rdata;
    endtask : read_reg
endmodule : rtccs_host_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/10ps
`include "rtccs_params.svh"
`default_nettype none
module tb_top;
    import rtccs_pkg::*;
    localparam logic [3:0] SEC = `RTCCS_ADDR_SEC;
    localparam logic [3:0] ADJ = `RTCCS_ADDR_ADJ;
    localparam logic [3:0] C1 = `RTCCS_ADDR_CTL1;
    localparam logic [3:0] C2 = `RTCCS_ADDR_CTL2;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic osc_clk = 1'b0;
    logic osc_tick = 1'b1;
    logic osc_halted = 1'b0;
    logic vdd_below_2v1 = 1'b0;
    logic vdd_below_1v3 = 1'b0;
    logic [1:0] alarm_match = 2'b00;
    rtccs_next_s next_count = 4'hf;
    logic [4:0] hour_bin = 5'h00;
    rtccs_req_s reg_req;
    logic [7:0] reg_rdata;
    logic [5:0] hour_code;
    logic sec_inc;
    logic irq_out_n;
    logic clkout_pin;
    logic [7:0] rd;
    int miscompares = 0;
    int n_compared = 0;
    int n;
    int hours[5] = '{0, 11, 12, 13, 23};

    initial begin
        forever #20 clock = ~clock;
    end

    // Clock-out source toggles each cycle; osc_tick held high keeps a second short
    always @(posedge clock) begin
        osc_clk <= ~osc_clk;
    end

    rtccs_core uut (.clock(clock), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .osc_clk(osc_clk), .osc_tick(osc_tick),
        .osc_halted(osc_halted), .vdd_below_2v1(vdd_below_2v1),
        .vdd_below_1v3(vdd_below_1v3), .alarm_match(alarm_match),
        .next_count(next_count), .hour_bin(hour_bin),
        .hour_code(hour_code), .sec_inc(sec_inc), .irq_out_n(irq_out_n),
        .clkout_pin(clkout_pin));

    rtccs_host_model host (.clock(clock), .reg_req(reg_req),
        .reg_rdata(reg_rdata));

    task automatic wrap_up;
        $display("Compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host.write_reg(a, d);
    endtask : wr

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        host.read_reg(a, rd);
        check(rd, exp);
    endtask : rchk

    task automatic irq_after(input int cyc, input logic exp);
        repeat (cyc) @(posedge clock);
        #1;
        check({7'h00, irq_out_n}, {7'h00, exp});
    endtask : irq_after

    task automatic clk_toggles(output int t);
        logic last;
        t = 0;
        repeat (3) @(posedge clock);
        #1;
        last = clkout_pin;
        repeat (6) begin
            @(posedge clock);
            #1;
            if (clkout_pin !== last) t++;
            last = clkout_pin;
        end
    endtask : clk_toggles

    function automatic logic [7:0] hour_exp(input int h, input logic h24);
        int v;
        v = h24 ? h : ((h % 12 == 0) ? 12 : h % 12);
        hour_exp = 8'((v / 10) * 16 + v % 10);
        if (!h24 && h >= 12) hour_exp = hour_exp | 8'h20;
    endfunction : hour_exp

    initial begin
        repeat (95000) @(posedge clock);
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rchk(C2, 8'h10);
        wr(C1, 8'hff);
        wr(ADJ, 8'h7f);
        rchk(C1, 8'h00);
        rchk(ADJ, 8'h00);
        wr(C2, 8'h00);
        rchk(C2, 8'h00);
        for (int f = 0; f < 2; f++) begin
            wr(C1, f ? 8'h20 : 8'h00);
            foreach (hours[i]) begin
                @(posedge clock);
                hour_bin <= 5'(hours[i]);
                repeat (3) @(posedge clock);
                #1;
                check({2'b00, hour_code}, hour_exp(hours[i], f[0]));
            end
        end
        wr(C1, 8'h08);
        rchk(C1, 8'h08);
        wr(C1, 8'h10);
        clk_toggles(n);
        check(8'(n), 8'h06);
        wr(C2, 8'h08);
        clk_toggles(n);
        check({7'h00, clkout_pin} + 8'(n), 8'h01);
        wr(C1, 8'h00);
        clk_toggles(n);
        check(8'(n), 8'h06);
        wr(C2, 8'h00);
        wr(C1, 8'h01);
        irq_after(2, 1'b0);
        rchk(C2, 8'h04);
        wr(C1, 8'h00);
        wr(C2, 8'h00);
        irq_after(2, 1'b1);
        for (int i = 0; i < 2; i++) begin
            for (int en = 0; en < 2; en++) begin
                wr(C1, en ? (8'h40 << i) : 8'h00);
                alarm_match[i] <= 1'b1;
                @(posedge clock);
                alarm_match[i] <= 1'b0;
                rchk(C2, 8'h00);
                irq_after(1600, !en);
                rchk(C2, en ? (8'h01 << i) : 8'h00);
                wr(C2, 8'h00);
                irq_after(2, 1'b1);
            end
        end
        wr(C1, 8'h00);
        wr(C2, 8'h80);
        vdd_below_2v1 <= 1'b1;
        rchk(C2, 8'h80);
        @(posedge clock);
        vdd_below_1v3 <= 1'b1;
        rchk(C2, 8'hc0);
        @(posedge clock);
        vdd_below_1v3 <= 1'b0;
        rchk(C2, 8'hc0);
        wr(C2, 8'hc0);
        rchk(C2, 8'hc0);
        wr(C2, 8'h80);
        rchk(C2, 8'h80);
        wr(C2, 8'h00);
        rchk(C2, 8'h40);
        @(posedge clock);
        vdd_below_2v1 <= 1'b0;
        wr(C2, 8'h00);
        rchk(C2, 8'h00);
        wr(C1, 8'h02);
        wr(SEC, 8'h00);
        irq_after(50, 1'b0);
        irq_after(8350, 1'b1);
        irq_after(8192, 1'b0);
        // Same divider phase is high at 1 Hz but low at 2 Hz
        wr(C1, 8'h03);
        irq_after(10, 1'b1);
        n = 0;
        while (irq_out_n !== 1'b0 && n < 17000) begin
            @(posedge clock);
            #1;
            n++;
        end
        check({7'h00, irq_out_n}, 8'h00);
        n = 0;
        while (sec_inc !== 1'b1 && n < 3000) begin
            @(posedge clock);
            #1;
            n++;
        end
        check(8'(n == `RTCCS_SEC_DLY_CYC), 8'h01);
        wr(C1, 8'h04);
        // Pulse phase leaves the flag set; clear it so the level edge counts
        wr(C2, 8'h00);
        irq_after(2, 1'b1);
        wr(SEC, 8'h00);
        n = 0;
        while (sec_inc !== 1'b1 && n < 34000) begin
            @(posedge clock);
            #1;
            n++;
        end
        check(8'(n > 32700 && n < 32800), 8'h01);
        check({7'h00, irq_out_n}, 8'h00);
        rchk(C2, 8'h04);
        wr(C2, 8'h00);
        irq_after(2, 1'b1);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
